// ---- hdl/rse_pkg.sv ----
// Constants and types for the Reed-Solomon stream encoder.
// Assumes one clock domain; register offsets are word indices on a plain port.
package rse_pkg;

    // Field, stream and port widths, and largest check count
    localparam int SYM_W = 8;
    localparam int MARK_W = 4;
    localparam int MAX_R = 32;
    localparam int CH_W = 7;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;

    // Register indices
    localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] REG_N = 4'h1;
    localparam logic [ADDR_W-1:0] REG_R = 4'h2;
    localparam logic [ADDR_W-1:0] REG_START = 4'h3;
    localparam logic [ADDR_W-1:0] REG_SCALE = 4'h4;
    localparam logic [ADDR_W-1:0] REG_POLY = 4'h5;
    localparam logic [ADDR_W-1:0] REG_STATUS = 4'h6;

    // Control field positions
    localparam int CTRL_VAR_N = 0;
    localparam int CTRL_VAR_R = 1;
    localparam int CTRL_BP = 2;

    // Status field positions
    localparam int STAT_MISS = 0;
    localparam int STAT_UNEXP = 1;
    localparam int STAT_INV = 2;
    localparam int STAT_FSM = 4;

    // Reset values
    localparam logic [2:0] CTRL_RST = 3'h0;
    localparam logic [SYM_W-1:0] N_RST = 8'hff;
    localparam logic [SYM_W-1:0] R_RST = 8'h20;
    localparam logic [SYM_W-1:0] START_RST = 8'h00;
    localparam logic [SYM_W-1:0] SCALE_RST = 8'h01;
    localparam logic [DATA_W-1:0] POLY_RST = 16'h0000;

    // Block length and check count limits
    localparam logic [SYM_W-1:0] N_MIN = 8'h03;
    localparam logic [SYM_W-1:0] R_MIN = 8'h02;

    // Default field polynomials for widths 3 to 12 (11, 19, 37 ... 4179)
    localparam logic [DATA_W-1:0] POLY_W3 = 16'h000b;
    localparam logic [DATA_W-1:0] POLY_W4 = 16'h0013;
    localparam logic [DATA_W-1:0] POLY_W5 = 16'h0025;
    localparam logic [DATA_W-1:0] POLY_W6 = 16'h0043;
    localparam logic [DATA_W-1:0] POLY_W7 = 16'h0089;
    localparam logic [DATA_W-1:0] POLY_W8 = 16'h011d;
    localparam logic [DATA_W-1:0] POLY_W9 = 16'h0211;
    localparam logic [DATA_W-1:0] POLY_W10 = 16'h0409;
    localparam logic [DATA_W-1:0] POLY_W11 = 16'h0805;
    localparam logic [DATA_W-1:0] POLY_W12 = 16'h1053;

    typedef enum logic [3:0] {
        S_IDLE = 4'b0001,
        S_BUILD = 4'b0010,
        S_DATA = 4'b0100,
        S_PARITY = 4'b1000
    } rse_state_e;

    // Default polynomial for a symbol width
    function automatic logic [DATA_W-1:0] rse_def_poly(input int w);
        case (w)
            3: rse_def_poly = POLY_W3;
            4: rse_def_poly = POLY_W4;
            5: rse_def_poly = POLY_W5;
            6: rse_def_poly = POLY_W6;
            7: rse_def_poly = POLY_W7;
            8: rse_def_poly = POLY_W8;
            9: rse_def_poly = POLY_W9;
            10: rse_def_poly = POLY_W10;
            11: rse_def_poly = POLY_W11;
            12: rse_def_poly = POLY_W12;
            default: rse_def_poly = POLY_W8;
        endcase
    endfunction

endpackage

// ---- hdl/rse_encoder.sv ----
// Systematic Reed-Solomon encoder with stream input, stream output and
// optional per-block control channel. Assumes source, sink and register
// master run on core_clk; no input needs synchronising.
//
// Notes on behaviour
// (R1) Each block is k info symbols passed unchanged, then n-k parity symbols.
// (R2) Full-length and shortened codes are both handled by the block length.
// (R3) Symbol width is a build constant of 3 to 12, here 8.
// (R4) Field polynomial is a register; zero selects the width's default.
// (R5) Defaults are 11,19,37,67,137,285,529,1033,2053,4179 for widths 3..12.
// (R6) Generator roots are alpha to h*(start+j), j from 0 to n-k-1.
// (R7) Generator start sets the exponent of the first root.
// (R8) Block length is legal from 3 up to 2^width-1.
// (R9) Info count is legal from max(n-32,1) up to n-2.
// (R10) Up to 128 channels interleave symbol by symbol on one stream.
// (R11) Input end marker only drives the event flags, never the encoding.
// (R12) Missing-marker flag when the marker is absent on the expected last.
// (R13) Unexpected-marker flag when the marker shows elsewhere.
// (R14) Invalid-control flag when a sampled control value is illegal.
// (R15) Variable length: new n per block; fixed check count moves k.
// (R16) Variable check count: new r per block, sampled and used for it.
// (R17) With back-pressure on, each output symbol holds until accepted.
// (R18) The system holds reset at least 2 clocks before sending symbols.
// (R19) Info flag marks the output of each block's last info symbol.
// (R20) Tag bits travel beside each symbol with the symbol's latency.
// (R21) Output end marker comes with the final symbol of a block.
// (R22) Clock enable low freezes every state bit and registered output.
// (R23) Parity is the remainder of division by g(x) in a shift register.
// (R24) Input ready is low while parity symbols are sent.
`timescale 1ns/1ps

module rse_encoder #(
    parameter int NUM_CH = 1
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [rse_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [rse_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [rse_pkg::DATA_W-1:0] reg_rdata,
    input wire logic s_valid,
    output logic s_ready,
    input wire logic [rse_pkg::SYM_W-1:0] s_data,
    input wire logic s_last,
    input wire logic [rse_pkg::MARK_W-1:0] s_tag,
    output logic m_valid,
    input wire logic m_ready,
    output logic [rse_pkg::SYM_W-1:0] m_data,
    output logic m_last,
    output logic m_info,
    output logic [rse_pkg::MARK_W-1:0] m_tag,
    input wire logic ctrl_valid,
    output logic ctrl_ready,
    input wire logic [rse_pkg::SYM_W-1:0] ctrl_n,
    input wire logic [rse_pkg::SYM_W-1:0] ctrl_r,
    output logic ev_last_missing,
    output logic ev_last_unexpected,
    output logic ev_ctrl_invalid
);

    localparam int SW = rse_pkg::SYM_W;
    localparam int MR = rse_pkg::MAX_R;
    localparam logic [rse_pkg::CH_W-1:0] CH_LAST = rse_pkg::CH_W'(NUM_CH - 1);
    localparam logic [SW-1:0] ONE = 8'h01;

    // All state of the block in one record
    typedef struct packed {
        rse_pkg::rse_state_e fsm;
        logic [SW-1:0] n, r, pos;
        logic [rse_pkg::CH_W-1:0] ch;
        logic [SW-1:0] bcnt;
        logic [SW-1:0] root;
        logic [MR:0][SW-1:0] gen;
        logic [NUM_CH-1:0][MR-1:0][SW-1:0] rem;
        logic ov;
        logic [SW-1:0] od;
        logic olast, oinfo;
        logic [rse_pkg::MARK_W-1:0] otag;
        logic ev_miss, ev_unexp, ev_inv;
        logic [2:0] cfg_ctrl;
        logic [SW-1:0] cfg_n, cfg_r, cfg_start, cfg_scale;
        logic [rse_pkg::DATA_W-1:0] cfg_poly;
        logic [2:0] sticky;
        logic [rse_pkg::DATA_W-1:0] rdata;
    } rse_st_s;

    rse_st_s st, next_st;

    // Field multiply, reduced by the low bits of the field polynomial
    function automatic logic [SW-1:0] rse_mul(input logic [SW-1:0] a, input logic [SW-1:0] b,
                                              input logic [SW-1:0] p);
        logic [SW-1:0] acc, sh;
        acc = '0;
        sh = a;
        for (int i = 0; i < SW; i++) begin
            acc = b[i] ? (acc ^ sh) : acc;
            sh = sh[SW-1] ? ({sh[SW-2:0], 1'b0} ^ p) : {sh[SW-2:0], 1'b0};
        end
        return acc;
    endfunction

    // Field power by square and multiply
    function automatic logic [SW-1:0] rse_pow(input logic [SW-1:0] base, input logic [SW-1:0] e,
                                              input logic [SW-1:0] p);
        logic [SW-1:0] res, b;
        res = ONE;
        b = base;
        for (int i = 0; i < SW; i++) begin
            res = e[i] ? rse_mul(res, b, p) : res;
            b = rse_mul(b, b, p);
        end
        return res;
    endfunction

    // Control pair check: n in 3..2^w-1, r in 2..MAX_R, k at least one
    function automatic logic rse_blk_ok(input logic [SW-1:0] nn, input logic [SW-1:0] rr);
        return (nn >= rse_pkg::N_MIN) && (rr >= rse_pkg::R_MIN) &&
               (int'(rr) <= MR) && (nn > rr);
    endfunction

    logic [rse_pkg::DATA_W-1:0] poly_eff;
    logic [SW-1:0] fpoly, alpha_h, root0, kk;
    logic var_n, var_r, var_any, bp_en, slot_free, fire, last_pos;

    // Field polynomial and generator seed; deep logic, so change them only while idle
    assign poly_eff = (st.cfg_poly == '0) ? rse_pkg::rse_def_poly(SW) : st.cfg_poly; // (R4) (R5)
    assign fpoly = poly_eff[SW-1:0]; // (R3)
    assign alpha_h = rse_pow(ONE << 1, st.cfg_scale, fpoly); // (R6)
    assign root0 = rse_pow(alpha_h, st.cfg_start, fpoly); // (R7)
    assign kk = st.n - st.r; // (R15)

    // Handshakes; the output slot frees when the sink takes it or back-pressure is off
    assign var_n = st.cfg_ctrl[rse_pkg::CTRL_VAR_N];
    assign var_r = st.cfg_ctrl[rse_pkg::CTRL_VAR_R];
    assign var_any = var_n | var_r;
    assign bp_en = st.cfg_ctrl[rse_pkg::CTRL_BP];
    assign slot_free = !st.ov || !bp_en || m_ready; // (R17)
    assign s_ready = (st.fsm == rse_pkg::S_DATA) && slot_free; // (R24)
    assign ctrl_ready = (st.fsm == rse_pkg::S_IDLE) && var_any;
    assign fire = ce && s_valid && s_ready;
    assign last_pos = (st.pos == kk - ONE);

    // Outputs straight from the state record
    assign m_valid = st.ov;
    assign m_data = st.od;
    assign m_last = st.olast;
    assign m_info = st.oinfo;
    assign m_tag = st.otag;
    assign reg_rdata = st.rdata;
    assign ev_last_missing = st.ev_miss;
    assign ev_last_unexpected = st.ev_unexp;
    assign ev_ctrl_invalid = st.ev_inv;

    // Next state: block sequencing, generator build, division and registers
    always_comb begin
        logic [SW-1:0] nn, rr, fb;
        logic [2:0] clr;
        nn = '0;
        rr = '0;
        fb = '0;
        clr = '0;
        next_st = st;
        if (ce) begin // (R22)
            next_st.ev_miss = 1'b0;
            next_st.ev_unexp = 1'b0;
            next_st.ev_inv = 1'b0;
            next_st.rdata = '0;
            next_st.ov = st.ov && bp_en && !m_ready; // Slot empties once taken
            case (st.fsm)
                rse_pkg::S_IDLE: begin
                    if (!var_any || ctrl_valid) begin
                        nn = var_n ? ctrl_n : st.cfg_n; // (R15)
                        rr = var_r ? ctrl_r : st.cfg_r; // (R16)
                        // Illegal pairs fall back to the register values
                        if (var_any && !rse_blk_ok(nn, rr)) begin
                            next_st.ev_inv = 1'b1; // (R14)
                            nn = st.cfg_n;
                            rr = st.cfg_r;
                        end
                        next_st.n = nn; // (R2) (R8) (R9)
                        next_st.r = rr;
                        next_st.gen = '0;
                        next_st.gen[0] = ONE;
                        next_st.root = root0;
                        next_st.bcnt = '0;
                        next_st.fsm = rse_pkg::S_BUILD;
                    end
                end
                rse_pkg::S_BUILD: begin
                    // One factor (x + root) per cycle; r cycles per block
                    next_st.gen[0] = rse_mul(st.root, st.gen[0], fpoly); // (R6)
                    for (int i = 1; i <= MR; i++) begin
                        next_st.gen[i] = st.gen[i-1] ^ rse_mul(st.root, st.gen[i], fpoly);
                    end
                    next_st.root = rse_mul(st.root, alpha_h, fpoly);
                    next_st.bcnt = st.bcnt + ONE;
                    if (st.bcnt == st.r - ONE) begin
                        next_st.fsm = rse_pkg::S_DATA;
                        next_st.pos = '0;
                        next_st.ch = '0;
                        next_st.rem = '0;
                    end
                end
                rse_pkg::S_DATA: begin
                    if (fire) begin
                        // Divide the shifted message by g(x); remainder per channel
                        fb = s_data ^ st.rem[st.ch][st.r - ONE]; // (R23)
                        next_st.rem[st.ch][0] = rse_mul(fb, st.gen[0], fpoly);
                        for (int i = 1; i < MR; i++) begin
                            if (i < int'(st.r)) begin
                                next_st.rem[st.ch][i] = st.rem[st.ch][i-1] ^
                                                        rse_mul(fb, st.gen[i], fpoly);
                            end
                        end
                        next_st.ov = 1'b1;
                        next_st.od = s_data; // (R1)
                        next_st.otag = s_tag; // (R20)
                        next_st.olast = 1'b0;
                        next_st.oinfo = last_pos; // (R19)
                        // Marker feeds the flags only, never the count
                        next_st.ev_miss = last_pos && !s_last; // (R11) (R12)
                        next_st.ev_unexp = !last_pos && s_last; // (R13)
                        if (st.ch == CH_LAST) begin // (R10)
                            next_st.ch = '0;
                            if (last_pos) begin
                                next_st.pos = '0;
                                next_st.fsm = rse_pkg::S_PARITY;
                            end else begin
                                next_st.pos = st.pos + ONE;
                            end
                        end else begin
                            next_st.ch = st.ch + 1'b1;
                        end
                    end
                end
                rse_pkg::S_PARITY: begin
                    if (slot_free) begin
                        // Highest remainder term leaves first, then the register shifts up
                        next_st.ov = 1'b1;
                        next_st.od = st.rem[st.ch][st.r - ONE]; // (R1) (R23)
                        next_st.otag = '0;
                        next_st.oinfo = 1'b0;
                        next_st.olast = (st.pos == st.r - ONE); // (R21)
                        next_st.rem[st.ch][0] = '0;
                        for (int i = 1; i < MR; i++) begin
                            next_st.rem[st.ch][i] = st.rem[st.ch][i-1];
                        end
                        if (st.ch == CH_LAST) begin // (R10)
                            next_st.ch = '0;
                            if (st.pos == st.r - ONE) begin
                                next_st.pos = '0;
                                next_st.fsm = rse_pkg::S_IDLE;
                            end else begin
                                next_st.pos = st.pos + ONE;
                            end
                        end else begin
                            next_st.ch = st.ch + 1'b1;
                        end
                    end
                end
                default: begin
                    next_st.fsm = rse_pkg::S_IDLE;
                end
            endcase
            // Register writes
            if (reg_wr) begin
                case (reg_addr)
                    rse_pkg::REG_CTRL: next_st.cfg_ctrl = reg_wdata[2:0];
                    rse_pkg::REG_N: next_st.cfg_n = reg_wdata[SW-1:0];
                    rse_pkg::REG_R: next_st.cfg_r = reg_wdata[SW-1:0];
                    rse_pkg::REG_START: next_st.cfg_start = reg_wdata[SW-1:0];
                    rse_pkg::REG_SCALE: next_st.cfg_scale = reg_wdata[SW-1:0];
                    rse_pkg::REG_POLY: next_st.cfg_poly = reg_wdata;
                    rse_pkg::REG_STATUS: clr = reg_wdata[2:0];
                    default: clr = '0;
                endcase
            end
            // Sticky flags: a new event wins over a clear in the same cycle
            next_st.sticky = (st.sticky & ~clr) |
                             {next_st.ev_inv, next_st.ev_unexp, next_st.ev_miss};
            // Read data stands only in the cycle after the strobe
            if (reg_rd) begin
                case (reg_addr)
                    rse_pkg::REG_CTRL: next_st.rdata = {13'h0000, st.cfg_ctrl};
                    rse_pkg::REG_N: next_st.rdata = {8'h00, st.cfg_n};
                    rse_pkg::REG_R: next_st.rdata = {8'h00, st.cfg_r};
                    rse_pkg::REG_START: next_st.rdata = {8'h00, st.cfg_start};
                    rse_pkg::REG_SCALE: next_st.rdata = {8'h00, st.cfg_scale};
                    rse_pkg::REG_POLY: next_st.rdata = st.cfg_poly;
                    rse_pkg::REG_STATUS: next_st.rdata = {8'h00, st.fsm, 1'b0, st.sticky};
                    default: next_st.rdata = '0;
                endcase
            end
        end
    end

    // State register; reset loads constants only
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st <= '0;
            st.fsm <= rse_pkg::S_IDLE;
            st.cfg_ctrl <= rse_pkg::CTRL_RST;
            st.cfg_n <= rse_pkg::N_RST;
            st.cfg_r <= rse_pkg::R_RST;
            st.cfg_start <= rse_pkg::START_RST;
            st.cfg_scale <= rse_pkg::SCALE_RST;
            st.cfg_poly <= rse_pkg::POLY_RST;
        end else begin
            st <= next_st;
        end
    end

    // Checks on the design's own behaviour
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    parity_no_input_a: assert property ( // (R24)
        (st.fsm == rse_pkg::S_PARITY) |-> !s_ready)
        else $error("input ready high during parity");

    data_pass_through_a: assert property ( // (R1)
        fire |=> (m_valid && m_data == $past(s_data)))
        else $error("info symbol not passed unchanged");

    info_flag_a: assert property ( // (R19)
        (fire && last_pos) |=> (m_info && !m_last)
        ##1 (!m_info || !$past(ce) || ($past(bp_en) && !$past(m_ready))))
        else $error("info flag wrong on last info symbol");

    block_end_mark_a: assert property ( // (R21)
        (ce && st.fsm == rse_pkg::S_PARITY && slot_free && st.pos == st.r - ONE)
        |=> (m_last && m_valid))
        else $error("end marker missing on final parity symbol");

    output_hold_a: assert property ( // (R17)
        (m_valid && bp_en && !m_ready) |=> (m_valid && $stable(m_data) && $stable(m_last)))
        else $error("output changed before it was accepted");

    ce_freeze_a: assert property ( // (R22)
        !ce |=> ($stable(st.fsm) && $stable(st.pos) && $stable(m_data) && $stable(m_valid)))
        else $error("state moved with clock enable low");

    missing_marker_a: assert property ( // (R12)
        (fire && last_pos && !s_last) |=> ev_last_missing ##1 (!$past(ce) || !ev_last_missing))
        else $error("missing marker not flagged for one cycle");

    unexpected_marker_a: assert property ( // (R13)
        (fire && !last_pos && s_last) |=> (ev_last_unexpected && !ev_last_missing))
        else $error("unexpected marker not flagged");

    tag_delay_a: assert property ( // (R20)
        fire |=> (m_tag == $past(s_tag)))
        else $error("tag bits not carried with symbol");

    ctrl_invalid_a: assert property ( // (R14)
        (ce && ctrl_ready && ctrl_valid && !rse_blk_ok(var_n ? ctrl_n : st.cfg_n,
                                                       var_r ? ctrl_r : st.cfg_r))
        |=> (ev_ctrl_invalid && st.fsm == rse_pkg::S_BUILD))
        else $error("illegal control not flagged");

    build_length_a: assert property ( // (R16)
        ($rose(st.fsm == rse_pkg::S_DATA)) |-> (st.gen[st.r] == ONE && st.bcnt == st.r))
        else $error("generator degree differs from check count");

endmodule

// ---- verification/rse_sink.sv ----
// Downstream consumer model for the encoder output stream.
// Assumes core_clk domain; bp mirrors the block's back-pressure enable.
`timescale 1ns/1ps
module rse_sink (
    input wire logic core_clk,
    input wire logic ce,
    input wire logic bp,
    input wire logic m_valid,
    input wire logic [rse_pkg::SYM_W-1:0] m_data,
    input wire logic m_last,
    input wire logic m_info,
    input wire logic [rse_pkg::MARK_W-1:0] m_tag,
    output logic m_ready
);
    logic [1:0] cnt = 2'h0;
    logic [13:0] got[$];
    // Stall one cycle in three so that held symbols really get exercised
    always @(posedge core_clk) begin
        cnt <= (cnt == 2'h2) ? 2'h0 : cnt + 2'h1;
        if (ce && m_valid && (m_ready || !bp)) begin
            got.push_back({m_last, m_info, m_tag, m_data});
        end
    end
    assign m_ready = !bp || (cnt != 2'h0);
endmodule

// ---- verification/tb_top.sv ----
// Self-checking bench for the Reed-Solomon stream encoder.
// Assumes rse_sink as consumer; the bench is source and register master.
`timescale 1ns/1ps
module tb_top;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic s_valid = 1'b0;
    logic s_last = 1'b0;
    logic ctrl_valid = 1'b0;
    logic bp = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic [15:0] reg_rdata;
    logic [15:0] v;
    logic [7:0] s_data = 8'h00;
    logic [7:0] ctrl_n = 8'h00;
    logic [7:0] ctrl_r = 8'h00;
    logic [3:0] s_tag = 4'h0;
    logic s_ready, m_valid, m_ready, m_last, m_info, ctrl_ready;
    logic ev_last_missing, ev_last_unexpected, ev_ctrl_invalid;
    logic [7:0] m_data;
    logic [3:0] m_tag;
    logic [3:0] ra[7] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h7};
    logic [15:0] rv[7] = '{16'h0, 16'hff, 16'h20, 16'h0, 16'h1, 16'h0, 16'h0};
    int error_cnt = 0;
    int tests_run = 0;
    int ev_m = 0;
    int ev_u = 0;
    int ev_i = 0;

    rse_encoder u_dut (.core_clk, .rst, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .s_valid, .s_ready, .s_data, .s_last, .s_tag, .m_valid, .m_ready,
        .m_data, .m_last, .m_info, .m_tag, .ctrl_valid, .ctrl_ready, .ctrl_n, .ctrl_r,
        .ev_last_missing, .ev_last_unexpected, .ev_ctrl_invalid);
    rse_sink u_sink (.core_clk, .ce, .bp, .m_valid, .m_data, .m_last, .m_info, .m_tag,
        .m_ready);

    always #4 core_clk = ~core_clk;

    // Count event pulses; a stretched pulse shows as an extra count
    always @(posedge core_clk) begin
        ev_m += (ev_last_missing === 1'b1);
        ev_u += (ev_last_unexpected === 1'b1);
        ev_i += (ev_ctrl_invalid === 1'b1);
    end

    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Extra edge at the end so back-to-back calls never re-drive the strobe at once
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(posedge core_clk);
        d = reg_rdata;
    endtask

    task automatic ctl(input int n, input int r);
        ctrl_n <= 8'(n);
        ctrl_r <= 8'(r);
        ctrl_valid <= 1'b1;
        @(posedge core_clk);
        while (ctrl_ready !== 1'b1) @(posedge core_clk);
        ctrl_valid <= 1'b0;
    endtask

    // Field multiply, reduced by the width-8 default polynomial
    function automatic logic [7:0] gmul(input logic [7:0] a, input logic [7:0] b);
        logic [7:0] p;
        p = 8'h00;
        for (int i = 7; i >= 0; i--) begin
            p = {p[6:0], 1'b0} ^ (p[7] ? 8'h1d : 8'h00);
            p = p ^ (b[i] ? a : 8'h00);
        end
        return p;
    endfunction

    function automatic logic [7:0] pw(input int e);
        logic [7:0] p;
        p = 8'h01;
        repeat (e) p = gmul(p, 8'h02);
        return p;
    endfunction

    // Send k symbols, then compare all n outputs against the sent data and a reference remainder
    task automatic blk(input int n, input int k, input int st, input int h, input int lp);
        logic [7:0] g[33];
        logic [7:0] rm[33];
        logic [7:0] fb;
        logic [7:0] d;
        logic [13:0] o;
        int r;
        int bad;
        r = n - k;
        bad = 0;
        g = '{default: 8'h00};
        rm = '{default: 8'h00};
        g[0] = 8'h01;
        for (int j = 0; j < r; j++) begin
            fb = pw(h * (st + j));
            for (int i = r; i > 0; i--) g[i] = g[i-1] ^ gmul(g[i], fb);
            g[0] = gmul(g[0], fb);
        end
        u_sink.got.delete();
        for (int i = 0; i < k; i++) begin
            d = 8'(i * 7 + 3);
            if (i == 2) begin
                ce <= 1'b0;
                s_data <= d; // A leak past the freeze would take this symbol
                @(posedge core_clk);
                o = {6'h00, m_data};
                @(posedge core_clk);
                chk("frozen", 16'(m_data), 16'(o[7:0]));
                ce <= 1'b1;
            end
            s_valid <= 1'b1;
            s_data <= d;
            s_tag <= 4'(i);
            s_last <= (i == lp);
            @(posedge core_clk);
            while (s_ready !== 1'b1) @(posedge core_clk);
            fb = d ^ rm[r-1];
            for (int j = r - 1; j > 0; j--) rm[j] = rm[j-1] ^ gmul(fb, g[j]);
            rm[0] = gmul(fb, g[0]);
        end
        s_valid <= 1'b0;
        for (int t = 0; t < 3000 && u_sink.got.size() < n; t++) begin
            @(posedge core_clk);
            bad += (s_ready === 1'b1);
        end
        chk("ready_in_parity", 16'(bad), 16'h0000);
        for (int i = 0; i < n; i++) begin
            o = u_sink.got[i];
            d = (i < k) ? 8'(i * 7 + 3) : rm[n-1-i];
            chk("data", 16'(o[7:0]), 16'(d));
            chk("tag", 16'(o[11:8]), (i < k) ? 16'(i % 16) : 16'h0000);
            chk("info_last", 16'(o[13:12]), 16'({i == n - 1, i == k - 1}));
        end
    endtask

    task automatic finish_test();
        if (error_cnt == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        repeat (6) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        foreach (ra[i]) begin
            rd(ra[i], v);
            chk("reg_reset", v, rv[i]);
        end
        wr(rse_pkg::REG_CTRL, 16'h0007);
        bp <= 1'b1;
        blk(255, 223, 0, 1, 222);
        chk("no_events", 16'(ev_m + ev_u + ev_i), 16'h0000);
        wr(rse_pkg::REG_START, 16'h0001);
        wr(rse_pkg::REG_SCALE, 16'h0002);
        ctl(12, 4);
        blk(12, 8, 1, 2, -1);
        chk("missing", 16'(ev_m), 16'h0001);
        ctl(9, 3);
        blk(9, 6, 1, 2, 0);
        chk("unexpected", 16'(ev_u), 16'h0001);
        wr(rse_pkg::REG_N, 16'h0008);
        wr(rse_pkg::REG_R, 16'h0002);
        ctl(5, 5);
        blk(8, 6, 1, 2, 5);
        chk("invalid", 16'(ev_i), 16'h0001);
        rd(rse_pkg::REG_STATUS, v);
        chk("status", v & 16'h0007, 16'h0007);
        wr(rse_pkg::REG_STATUS, 16'h0007);
        rd(rse_pkg::REG_STATUS, v);
        chk("status_clr", v & 16'h0007, 16'h0000);
        // Length only, no back-pressure; an ignored r of zero must not flag
        wr(rse_pkg::REG_CTRL, 16'h0001);
        bp <= 1'b0;
        ctl(10, 0);
        blk(10, 8, 1, 2, 7);
        chk("var_n_only", 16'(ev_i), 16'h0001);
        finish_test();
    end

    // Cut a hang short; the full run needs well under a tenth of this
    initial begin
        #400000;
        error_cnt++;
        finish_test();
    end
endmodule
